// ### dv/ldoc_chk.sv
// Purpose: port assertions for the regulator control block
// Assumes: nvm inputs hold still for the whole run
// Notes:   bound into ldoc_top
`timescale 1ns/1ns
module ldoc_chk
(
  // Clock and reset
  input  wire logic        MCLK,
  input  wire logic        RST,
  // Bus
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic        HREADY,
  input  wire logic [31:0] HRDATA,
  input  wire logic        HREADYOUT,
  input  wire logic        HRESP,
  // Controls
  input  wire logic [1:0]  NVM_SWITCH_MODE_SELECT,
  input  wire logic [1:0]  REG1_MODE,
  input  wire logic [3:0]  REG1_CODE,
  input  wire logic [12:0] REG1_MV,
  input  wire logic [1:0]  REG2_MODE,
  input  wire logic [3:0]  REG2_CODE,
  input  wire logic [12:0] REG2_MV
);
  localparam logic [12:0] MV_TAB [16] = '{13'd800, 13'd900, 13'd1000,
    13'd1100, 13'd1200, 13'd1500, 13'd1600, 13'd1800, 13'd1850, 13'd2500,
    13'd3000, 13'd3150, 13'd3300, 13'd3350, 13'd4500, 13'd5000};
  logic rd_bad;
  // Offsets above the last register
  assign rd_bad = HSEL && HREADY && HTRANS[1] && !HWRITE &&
                  (HADDR[7:0] > 8'h0F);

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);

  a_mv_decode1: assert property (REG1_MV == MV_TAB[REG1_CODE])
    else $error("reg1 millivolts do not match code");
  a_mv_decode2: assert property (REG2_MV == MV_TAB[REG2_CODE])
    else $error("reg2 millivolts do not match code");
  a_mode_legal: assert property (REG1_MODE != 2'b11 &&
                                 REG2_MODE != 2'b11)
    else $error("illegal regulator mode");
  a_switch_nvm: assert property (REG1_MODE == 2'b10
                                 |-> NVM_SWITCH_MODE_SELECT[0])
    else $error("reg1 switch mode without nvm select");
  a_regul_nvm: assert property (REG2_MODE == 2'b01
                                |-> !NVM_SWITCH_MODE_SELECT[1])
    else $error("reg2 regulating with nvm switch select");
  a_reset_off: assert property (disable iff (1'b0) RST
    |=> REG1_MODE == 2'b00 && REG2_MODE == 2'b00 && REG1_CODE == 4'h0)
    else $error("outputs not cleared by reset");
  a_bus_okay: assert property (HREADYOUT && !HRESP)
    else $error("bus not ready or not okay");
  a_unmapped_zero: assert property (rd_bad |=> HRDATA == 32'h0000_0000)
    else $error("unmapped read not zero");

  c_switch: cover property (REG2_MODE == 2'b10);
  c_standby_reg: cover property (REG1_MODE == 2'b01 ##1 REG1_MODE == 2'b00);
  c_unmapped: cover property (rd_bad);
endmodule

bind ldoc_top ldoc_chk chk_u (.MCLK(MCLK), .RST(RST), .HSEL(HSEL),
  .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HREADY(HREADY),
  .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
  .NVM_SWITCH_MODE_SELECT(NVM_SWITCH_MODE_SELECT),
  .REG1_MODE(REG1_MODE), .REG1_CODE(REG1_CODE), .REG1_MV(REG1_MV),
  .REG2_MODE(REG2_MODE), .REG2_CODE(REG2_CODE), .REG2_MV(REG2_MV));

// ### dv/ldoc_seq_model.sv
// Purpose: power-state sequencer and pin driver beside the block
// Assumes: bench posts requests, model applies them one edge later
// Notes:   outputs start low so no input floats at time zero
`timescale 1ns/1ns
module ldoc_seq_model
(
  // Clock
  input  wire logic mclk,
  // Requests from the bench
  input  wire logic sb_req,
  input  wire logic en_req,
  input  wire logic sel_req,
  // Toward the block
  output logic      standby = 1'b0,
  output logic      en_pin  = 1'b0,
  output logic      sel_pin = 1'b0
);
  always @(posedge mclk)
  begin
    standby <= sb_req;
    en_pin  <= en_req;
    sel_pin <= sel_req;
  end
endmodule

// ### dv/tb.sv
// Purpose: self-checking bench for the regulator control block
// Assumes: reg1 regulates, reg2 is a load switch, reg1 in sequence
// Notes:   pin codes overridden to tell them from defaults
`timescale 1ns/1ns
module tb;
  import ldoc_pkg::*;
  localparam logic [3:0] HI_C = 4'hA;
  localparam logic [3:0] LO_C = 4'h2;
  localparam logic [12:0] MV_TAB [16] = '{13'd800, 13'd900, 13'd1000,
    13'd1100, 13'd1200, 13'd1500, 13'd1600, 13'd1800, 13'd1850, 13'd2500,
    13'd3000, 13'd3150, 13'd3300, 13'd3350, 13'd4500, 13'd5000};
  typedef struct {logic sb; logic [11:0] ctl; logic [1:0] m1;
                  logic [3:0] c1; logic [1:0] m2;} ldoc_row_s;
  ldoc_row_s rows [7] = '{'{1'b0, 12'h351, 2'b01, 4'h5, 2'b10},
    '{1'b1, 12'h352, 2'b01, 4'h3, 2'b10}, '{1'b0, 12'h352, 2'b00, 4'h5, 2'b00},
    '{1'b1, 12'h351, 2'b00, 4'h3, 2'b00}, '{1'b0, 12'hFF3, 2'b01, 4'hF, 2'b10},
    '{1'b1, 12'hFF3, 2'b01, 4'hF, 2'b10}, '{1'b0, 12'h000, 2'b00, 4'h0, 2'b00}};
  logic        mclk = 0, rst = 1, hsel = 0, hwrite = 0;
  logic        sb_req = 0, en_req = 0, sel_req = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
  logic [1:0]  htrans = 0, m1, m2;
  logic        hready, hresp, standby, en_pin, sel_pin;
  logic [3:0]  c1, c2;
  logic [12:0] v1, v2;
  int          err_total = 0, checked = 0, cyc = 0;

  initial forever #25 mclk = ~mclk;

  ldoc_seq_model seq_u (.mclk(mclk), .sb_req(sb_req), .en_req(en_req),
    .sel_req(sel_req), .standby(standby), .en_pin(en_pin), .sel_pin(sel_pin));

  ldoc_top #(.PIN_HIGH_CODE(HI_C), .PIN_LOW_CODE(LO_C)) dut_u (.MCLK(mclk),
    .RST(rst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
    .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata),
    .HREADYOUT(hready), .HRESP(hresp), .STANDBY(standby),
    .SEQ_MEMBER(2'h1), .NVM_SWITCH_MODE_SELECT(2'h2),
    .NVM_DEFAULT_VOLTAGE_CODE1(4'h9), .NVM_DEFAULT_VOLTAGE_CODE2(4'h5),
    .VOLTAGE_SELECT_PIN(sel_pin), .SECOND_REG_ENABLE_PIN(en_pin),
    .REG1_MODE(m1), .REG1_CODE(c1), .REG1_MV(v1),
    .REG2_MODE(m2), .REG2_CODE(c2), .REG2_MV(v2));

  task automatic complete_run;
    if (err_total == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] got, exp);
    checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // ==========================================================
  // Bus master, single word transfers
  task automatic ahb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    @(posedge mclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge mclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge mclk); while (hready !== 1'b1);
    q = hrdata;
  endtask

  // Outputs trail requests by two edges; one spare
  task automatic wt;
    repeat (3) @(posedge mclk);
    #1;
  endtask

  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_total++;
      complete_run();
    end
  end

  initial
  begin
    repeat (5) @(posedge mclk);
    #1;
    chk("mode1", m1, 2'b00);
    chk("mv1", v1, 13'd800);
    @(posedge mclk);
    rst <= 1'b0;
    wt();
    chk("mode1", m1, 2'b01);
    chk("code1", c1, 4'h9);
    chk("mode2", m2, 2'b00);
    ahb(1'b0, 8'h00, 0, rd);
    chk("ctrl1", rd, 32'h0000_0993);
    ahb(1'b0, 8'h04, 0, rd);
    chk("ctrl2", rd, 32'h0000_0550);
    ahb(1'b0, 8'h10, 0, rd);
    chk("unmapped", rd, 32'h0);
    foreach (rows[i])
    begin
      ahb(1'b1, 8'h00, {20'h0, rows[i].ctl}, rd);
      ahb(1'b1, 8'h04, {20'h0, rows[i].ctl}, rd);
      sb_req <= rows[i].sb;
      wt();
      chk("mode1", m1, rows[i].m1);
      chk("mode2", m2, rows[i].m2);
      chk("code1", c1, rows[i].c1);
      chk("code2", c2, rows[i].c1);
    end
    sb_req <= 1'b0;
    for (int i = 0; i < 16; i++)
    begin
      ahb(1'b1, 8'h00, {24'h0, i[3:0], 4'h1}, rd);
      wt();
      chk("mv1", v1, MV_TAB[i]);
    end
    ahb(1'b1, 8'h0C, 32'h1, rd);
    en_req <= 1'b1;
    sel_req <= 1'b1;
    wt();
    chk("mode2", m2, 2'b10);
    chk("code2", c2, HI_C);
    chk("mv2", v2, MV_TAB[HI_C]);
    sel_req <= 1'b0;
    sb_req <= 1'b1;
    wt();
    chk("code2", c2, LO_C);
    chk("mv2", v2, MV_TAB[LO_C]);
    chk("mode2", m2, 2'b10);
    en_req <= 1'b0;
    wt();
    chk("mode2", m2, 2'b00);
    // Mid-run reset with the enable pin high: pin control must drop
    @(posedge mclk);
    rst <= 1'b1;
    sb_req <= 1'b0;
    en_req <= 1'b1;
    repeat (2) @(posedge mclk);
    #1;
    chk("mode1", m1, 2'b00);
    chk("mv1", v1, 13'd800);
    @(posedge mclk);
    rst <= 1'b0;
    wt();
    chk("mode1", m1, 2'b01);
    chk("code1", c1, 4'h9);
    chk("mode2", m2, 2'b00);
    ahb(1'b0, 8'h0C, 0, rd);
    chk("hwctrl", rd, 32'h0);
    complete_run();
  end
endmodule

// ### rtl/ldoc_chan.sv
// Purpose: one regulator's mode and voltage code selection
// Assumes: inputs synchronous to the clock
// Notes:   outputs registered
`timescale 1ns/1ns
module ldoc_chan
  import ldoc_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Settings
  input  wire logic       standby,
  input  wire logic       run_en,
  input  wire logic       stby_en,
  input  wire logic [3:0] run_code,
  input  wire logic [3:0] stby_code,
  input  wire logic       switch_mode_select,
  // Regulator controls
  output logic      [1:0] mode,
  output logic      [3:0] code,
  output logic     [12:0] millivolts
);

  logic       en_cur;
  logic [3:0] code_cur;

  // ==========================================================
  // Active-mode selection
  always_comb
  begin
    en_cur   = standby ? stby_en   : run_en;
    code_cur = standby ? stby_code : run_code;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      mode <= LDOC_MODE_RST;
    else if (!en_cur)
      mode <= LDOC_OFF_PD;
    else if (switch_mode_select)
      mode <= LDOC_SWITCH;
    else
      mode <= LDOC_REG;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      code       <= LDOC_CODE_RST;
      millivolts <= ldoc_code_mv(LDOC_CODE_RST);
    end
    else
    begin
      code       <= code_cur;
      millivolts <= ldoc_code_mv(code_cur);
    end
  end

endmodule

// ### rtl/ldoc_pkg.sv
// Purpose: constants for the two-regulator enable and voltage control
// Assumes: one 20 MHz clock, AHB-Lite register access
// Notes:   codes are 4 bits, one word per register
package ldoc_pkg;

  // ==========================================================
  // Register offsets
  localparam logic [7:0] LDOC_CTRL1_OFS   = 8'h00;
  localparam logic [7:0] LDOC_CTRL2_OFS   = 8'h04;
  localparam logic [7:0] LDOC_STATUS_OFS  = 8'h08;
  localparam logic [7:0] LDOC_HWCTRL_OFS  = 8'h0C;

  // ==========================================================
  // Control register fields
  localparam int LDOC_RUN_EN_BIT   = 0;
  localparam int LDOC_STBY_EN_BIT  = 1;
  localparam int LDOC_RUN_V_LSB    = 4;
  localparam int LDOC_STBY_V_LSB   = 8;
  localparam int LDOC_CODE_W       = 4;

  // Status fields, per regulator byte
  localparam int LDOC_ST_MODE_LSB  = 0;
  localparam int LDOC_ST_CODE_LSB  = 4;
  localparam int LDOC_ST_REG2_LSB  = 8;
  localparam int LDOC_ST_STBY_BIT  = 16;

  // Hardware control field
  localparam int LDOC_HW_EN_BIT    = 0;

  // ==========================================================
  // Output modes: off with pulldown, regulating, load switch
  typedef enum logic [1:0]
  {
    LDOC_OFF_PD = 2'b00,
    LDOC_REG    = 2'b01,
    LDOC_SWITCH = 2'b10
  } ldoc_mode_e;

  // Reset values
  localparam logic [1:0] LDOC_MODE_RST  = 2'b00;
  localparam logic [3:0] LDOC_CODE_RST  = 4'h0;
  localparam logic [31:0] LDOC_ZERO32   = 32'h0000_0000;

  // AHB codes
  localparam logic [1:0] LDOC_HTRANS_NONSEQ = 2'b10;
  localparam logic [1:0] LDOC_HTRANS_SEQ    = 2'b11;

  // Output voltage of a code in millivolts
  function automatic logic [12:0] ldoc_code_mv(input logic [3:0] code);
    case (code)
      4'h0:    ldoc_code_mv = 13'd800;
      4'h1:    ldoc_code_mv = 13'd900;
      4'h2:    ldoc_code_mv = 13'd1000;
      4'h3:    ldoc_code_mv = 13'd1100;
      4'h4:    ldoc_code_mv = 13'd1200;
      4'h5:    ldoc_code_mv = 13'd1500;
      4'h6:    ldoc_code_mv = 13'd1600;
      4'h7:    ldoc_code_mv = 13'd1800;
      4'h8:    ldoc_code_mv = 13'd1850;
      4'h9:    ldoc_code_mv = 13'd2500;
      4'hA:    ldoc_code_mv = 13'd3000;
      4'hB:    ldoc_code_mv = 13'd3150;
      4'hC:    ldoc_code_mv = 13'd3300;
      4'hD:    ldoc_code_mv = 13'd3350;
      4'hE:    ldoc_code_mv = 13'd4500;
      default: ldoc_code_mv = 13'd5000;
    endcase
  endfunction

endpackage

// ### rtl/ldoc_top.sv
// Purpose: enable and voltage control for two linear regulators
// Assumes: AHB-Lite slave, single word transfers, OKAY only
// Notes:   defaults loaded from nvm inputs one cycle after reset
//
// Implementation choices: the register addresses and the AHB-Lite register port.
`timescale 1ns/1ns
module ldoc_top
  import ldoc_pkg::*;
#(
  parameter logic [3:0] PIN_HIGH_CODE = 4'hC,
  parameter logic [3:0] PIN_LOW_CODE  = 4'h7
)
(
  // Clock and reset
  input  wire logic        MCLK,
  input  wire logic        RST,
  // AHB-Lite slave
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic      [31:0] HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  // System state and nonvolatile defaults
  input  wire logic        STANDBY,
  input  wire logic [1:0]  SEQ_MEMBER,
  input  wire logic [1:0]  NVM_SWITCH_MODE_SELECT,
  input  wire logic [3:0]  NVM_DEFAULT_VOLTAGE_CODE1,
  input  wire logic [3:0]  NVM_DEFAULT_VOLTAGE_CODE2,
  // Second regulator pins
  input  wire logic        VOLTAGE_SELECT_PIN,
  input  wire logic        SECOND_REG_ENABLE_PIN,
  // Regulator controls
  output logic      [1:0]  REG1_MODE,
  output logic      [3:0]  REG1_CODE,
  output logic      [12:0] REG1_MV,
  output logic      [1:0]  REG2_MODE,
  output logic      [3:0]  REG2_CODE,
  output logic      [12:0] REG2_MV
);

  // ==========================================================
  // Register state
  logic [1:0] reg_run_enable_r;
  logic [1:0] reg_standby_enable_r;
  logic [3:0] run_voltage_code_r     [2];
  logic [3:0] standby_voltage_code_r [2];
  logic [1:0] switch_mode_select_r;
  logic       hw_ctrl_r;
  logic       loaded_r;

  // Bus data-phase state
  logic       wr_pend_r;
  logic [7:0] wr_addr_r;
  logic       rd_go;
  logic       wr_go;
  logic       ctrl_wr;
  logic       ctrl_sel;
  logic       hwctrl_wr;

  // Read mux output
  logic [31:0] rd_word;

  // Effective second-regulator settings
  logic       r2_run_en;
  logic       r2_stby_en;
  logic [3:0] r2_run_code;
  logic [3:0] r2_stby_code;

  // ==========================================================
  // AHB address phase
  always_comb
  begin
    rd_go = HSEL && HREADY && HTRANS[1] && !HWRITE;
    wr_go = HSEL && HREADY && HTRANS[1] && HWRITE;
  end

  always_ff @(posedge MCLK)
  begin
    if (RST)
      wr_pend_r <= 1'b0;
    else
      wr_pend_r <= wr_go;
  end

  // Offset kept for the data phase of a write
  always_ff @(posedge MCLK)
  begin
    if (RST)
      wr_addr_r <= 8'h00;
    else if (wr_go)
      wr_addr_r <= HADDR[7:0];
  end

  // Zero wait states: every register answers in one cycle
  always_ff @(posedge MCLK)
  begin
    if (RST)
      HREADYOUT <= 1'b1;
    else
      HREADYOUT <= 1'b1;
  end

  // Always OKAY: unmapped offsets read zero rather than fault
  always_ff @(posedge MCLK)
  begin
    if (RST)
      HRESP <= 1'b0;
    else
      HRESP <= 1'b0;
  end

  // ==========================================================
  // Power-up load, then software writes
  // Load waits one cycle so no port reaches an async path
  always_ff @(posedge MCLK)
  begin
    if (RST)
      loaded_r <= 1'b0;
    else
      loaded_r <= 1'b1;
  end

  // Either control word; offset bit 2 picks the regulator
  function automatic logic is_ctrl(input logic [7:0] ofs);
    is_ctrl = (ofs == LDOC_CTRL1_OFS) || (ofs == LDOC_CTRL2_OFS);
  endfunction

  // Writes land at the end of the data phase, when HWDATA stands
  always_comb
  begin
    ctrl_wr   = loaded_r && wr_pend_r && is_ctrl(wr_addr_r);
    hwctrl_wr = loaded_r && wr_pend_r && (wr_addr_r == LDOC_HWCTRL_OFS);
    ctrl_sel  = wr_addr_r[2];
  end

  // Enables follow sequence membership at load; a later write may
  // turn a regulator off even in the mode it is running in
  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      reg_run_enable_r     <= 2'b00;
      reg_standby_enable_r <= 2'b00;
    end
    else if (!loaded_r)
    begin
      reg_run_enable_r     <= SEQ_MEMBER;
      reg_standby_enable_r <= SEQ_MEMBER;
    end
    else if (ctrl_wr)
    begin
      reg_run_enable_r[ctrl_sel]     <= HWDATA[LDOC_RUN_EN_BIT];
      reg_standby_enable_r[ctrl_sel] <= HWDATA[LDOC_STBY_EN_BIT];
    end
  end

  // Run and standby voltage codes
  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      for (int i = 0; i < 2; i++)
      begin
        run_voltage_code_r[i]     <= LDOC_CODE_RST;
        standby_voltage_code_r[i] <= LDOC_CODE_RST;
      end
    end
    else if (!loaded_r)
    begin
      run_voltage_code_r[0]     <= NVM_DEFAULT_VOLTAGE_CODE1;
      standby_voltage_code_r[0] <= NVM_DEFAULT_VOLTAGE_CODE1;
      run_voltage_code_r[1]     <= NVM_DEFAULT_VOLTAGE_CODE2;
      standby_voltage_code_r[1] <= NVM_DEFAULT_VOLTAGE_CODE2;
    end
    else if (ctrl_wr)
    begin
      run_voltage_code_r[ctrl_sel]     <=
        HWDATA[LDOC_RUN_V_LSB +: LDOC_CODE_W];
      standby_voltage_code_r[ctrl_sel] <=
        HWDATA[LDOC_STBY_V_LSB +: LDOC_CODE_W];
    end
  end

  // Switch mode is nonvolatile only, so software cannot flip a
  // regulator into a pass switch at the wrong input voltage
  always_ff @(posedge MCLK)
  begin
    if (RST)
      switch_mode_select_r <= 2'b00;
    else if (!loaded_r)
      switch_mode_select_r <= NVM_SWITCH_MODE_SELECT;
  end

  // Pin control of the second regulator
  always_ff @(posedge MCLK)
  begin
    if (RST)
      hw_ctrl_r <= 1'b0;
    else if (hwctrl_wr)
      hw_ctrl_r <= HWDATA[LDOC_HW_EN_BIT];
  end

  // ==========================================================
  // Read data
  function automatic logic [31:0] ctrl_word(input logic       ren,
                                            input logic       sen,
                                            input logic [3:0] rc,
                                            input logic [3:0] sc);
    ctrl_word = LDOC_ZERO32;
    ctrl_word[LDOC_RUN_EN_BIT]                     = ren;
    ctrl_word[LDOC_STBY_EN_BIT]                    = sen;
    ctrl_word[LDOC_RUN_V_LSB +: LDOC_CODE_W]       = rc;
    ctrl_word[LDOC_STBY_V_LSB +: LDOC_CODE_W]      = sc;
  endfunction

  function automatic logic [31:0] status_word(input logic [1:0] m1,
                                              input logic [3:0] c1,
                                              input logic [1:0] m2,
                                              input logic [3:0] c2,
                                              input logic       sb);
    status_word = LDOC_ZERO32;
    status_word[LDOC_ST_MODE_LSB +: 2]                    = m1;
    status_word[LDOC_ST_CODE_LSB +: LDOC_CODE_W]          = c1;
    status_word[LDOC_ST_REG2_LSB + LDOC_ST_MODE_LSB +: 2] = m2;
    status_word[LDOC_ST_REG2_LSB + LDOC_ST_CODE_LSB +: LDOC_CODE_W]
                                                          = c2;
    status_word[LDOC_ST_STBY_BIT]                         = sb;
  endfunction

  // Read mux, decoded from the address phase
  always_comb
  begin
    rd_word = LDOC_ZERO32;
    case (HADDR[7:0])
      LDOC_CTRL1_OFS:
        rd_word = ctrl_word(reg_run_enable_r[0], reg_standby_enable_r[0],
                            run_voltage_code_r[0],
                            standby_voltage_code_r[0]);
      LDOC_CTRL2_OFS:
        rd_word = ctrl_word(reg_run_enable_r[1], reg_standby_enable_r[1],
                            run_voltage_code_r[1],
                            standby_voltage_code_r[1]);
      LDOC_STATUS_OFS:
        rd_word = status_word(REG1_MODE, REG1_CODE, REG2_MODE, REG2_CODE,
                              STANDBY);
      LDOC_HWCTRL_OFS:
        rd_word[LDOC_HW_EN_BIT] = hw_ctrl_r;
      default:
        rd_word = LDOC_ZERO32;
    endcase
  end

  // Loaded only when a read is taken, so it stands in the data phase
  always_ff @(posedge MCLK)
  begin
    if (RST)
      HRDATA <= LDOC_ZERO32;
    else if (rd_go)
      HRDATA <= rd_word;
  end

  // ==========================================================
  // Pin override of the second regulator
  // Pin enable applies in both modes while pin control is on
  always_comb
  begin
    if (hw_ctrl_r)
    begin
      r2_run_en  = SECOND_REG_ENABLE_PIN;
      r2_stby_en = SECOND_REG_ENABLE_PIN;
    end
    else
    begin
      r2_run_en  = reg_run_enable_r[1];
      r2_stby_en = reg_standby_enable_r[1];
    end
  end

  // Register codes are kept, so they return when pin control ends
  always_comb
  begin
    if (hw_ctrl_r)
    begin
      r2_run_code  = VOLTAGE_SELECT_PIN ? PIN_HIGH_CODE
                                        : PIN_LOW_CODE;
      r2_stby_code = r2_run_code;
    end
    else
    begin
      r2_run_code  = run_voltage_code_r[1];
      r2_stby_code = standby_voltage_code_r[1];
    end
  end

  // ==========================================================
  // Regulator channels
  // First regulator: register settings only
  ldoc_chan u_chan1
  (
    .clk                (MCLK),
    .rst                (RST),
    .standby            (STANDBY),
    .run_en             (reg_run_enable_r[0]),
    .stby_en            (reg_standby_enable_r[0]),
    .run_code           (run_voltage_code_r[0]),
    .stby_code          (standby_voltage_code_r[0]),
    .switch_mode_select (switch_mode_select_r[0]),
    .mode               (REG1_MODE),
    .code               (REG1_CODE),
    .millivolts         (REG1_MV)
  );

  // Second regulator: pin override already applied
  ldoc_chan u_chan2
  (
    .clk                (MCLK),
    .rst                (RST),
    .standby            (STANDBY),
    .run_en             (r2_run_en),
    .stby_en            (r2_stby_en),
    .run_code           (r2_run_code),
    .stby_code          (r2_stby_code),
    .switch_mode_select (switch_mode_select_r[1]),
    .mode               (REG2_MODE),
    .code               (REG2_CODE),
    .millivolts         (REG2_MV)
  );

endmodule
